//--- diag_calib_pkg.sv
// shared constants and types for the diagnostic and calibration parameter bank
package diag_calib_pkg;
  // word addresses of the parameter bank
  localparam logic [15:0] ADDR_INPUT_STATE  = 16'h040e;
  localparam logic [15:0] ADDR_KEYPAD       = 16'h0410;
  localparam logic [15:0] ADDR_OUTPUT_STATE = 16'h0412;
  localparam logic [15:0] ADDR_CAL_CMD      = 16'h0414;
  localparam logic [15:0] ADDR_SPD_TRIM_A   = 16'h0416;
  localparam logic [15:0] ADDR_SPD_TRIM_B   = 16'h0418;
  localparam logic [15:0] ADDR_TRQ_TRIM_A   = 16'h041a;
  localparam logic [15:0] ADDR_TRQ_TRIM_B   = 16'h041a;
  localparam logic [15:0] ADDR_V_TRIM_A     = 16'h041e;
  localparam logic [15:0] ADDR_V_TRIM_B     = 16'h0420;
  localparam logic [15:0] ADDR_W_TRIM_A     = 16'h0422;
  localparam logic [15:0] ADDR_W_TRIM_B     = 16'h0424;
  localparam logic [15:0] ADDR_THERM_CAL    = 16'h0426;
  localparam logic [15:0] ADDR_MON_TRIM1    = 16'h0428;
  localparam logic [15:0] ADDR_MON_TRIM2    = 16'h042a;
  localparam logic [15:0] ADDR_SPD_OFFSET   = 16'h042c;
  // decoded register index
  localparam logic [4:0]  IDX_INPUT_STATE   = 5'h00;
  localparam logic [4:0]  IDX_KEYPAD        = 5'h01;
  localparam logic [4:0]  IDX_OUTPUT_STATE  = 5'h02;
  localparam logic [4:0]  IDX_CAL_CMD       = 5'h03;
  localparam logic [4:0]  IDX_TRIM_BASE     = 5'h04;
  localparam logic [4:0]  IDX_TRQ_TRIM_A    = 5'h06;
  localparam logic [4:0]  IDX_MON_TRIM1     = 5'h0d;
  localparam logic [4:0]  IDX_MON_TRIM2     = 5'h0e;
  localparam logic [4:0]  IDX_SPD_OFFSET    = 5'h0f;
  localparam logic [4:0]  IDX_NONE          = 5'h1f;
  // trim array slots
  localparam int          NUM_TRIMS         = 9;
  localparam logic [3:0]  SLOT_TRQ_B        = 4'h3;
  localparam logic [3:0]  SLOT_THERM        = 4'h8;
  // field widths and ranges
  localparam int          NUM_DI            = 9;
  localparam int          NUM_KEYS          = 5;
  localparam int          NUM_DO            = 5;
  localparam logic [15:0] INPUT_STATE_MAX   = 16'h01ff;
  localparam logic [15:0] CAL_CMD_MAX       = 16'h0006;
  localparam logic [15:0] CAL_CMD_ALL_DRIFT = 16'h0005;
  localparam logic [15:0] CAL_CMD_THERM     = 16'h0006;
  localparam logic [15:0] TRIM_MAX          = 16'h7fff;
  localparam logic [15:0] THERM_MIN         = 16'h0001;
  localparam logic [15:0] THERM_MAX         = 16'h0003;
  localparam logic signed [15:0] MON_MIN    = -16'sd800;
  localparam logic signed [15:0] MON_MAX    = 16'sd800;
  localparam logic signed [15:0] OFFSET_MIN = -16'sd5000;
  localparam logic signed [15:0] OFFSET_MAX = 16'sd5000;
  // protection mode values
  localparam logic [15:0] PROT_CAL_ENABLE   = 16'd20;
  localparam logic [15:0] PROT_TRIM_UNLOCK  = 16'd22;
  localparam logic [15:0] PROT_KEEP_TRIMS   = 16'd10;
  // reset values
  localparam logic [15:0] INPUT_STATE_RST   = 16'h0000;
  localparam logic [15:0] CAL_CMD_RST       = 16'h0000;
  localparam logic [15:0] SPD_OFFSET_RST    = 16'h0000;
  localparam logic [15:0] MON_TRIM2_RST     = 16'h0000;

  typedef struct packed {
    logic [NUM_DI-1:0]           sw_in;
    logic [15:0]                 cal_cmd;
    logic [NUM_TRIMS-1:0][15:0]  trim;
    logic [1:0][15:0]            mon;
    logic [15:0]                 spd_off;
    logic [NUM_DI-1:0]           di_final;
    logic [15:0]                 rd_data;
    logic                        rd_valid;
    logic                        wr_ack;
    logic                        acc_err;
    logic                        cal_start;
    logic [4:0]                  cal_sel;
    logic signed [16:0]          speed_sum;
  } state_t;
endpackage

//--- diag_io_calib_params.sv
// diagnostic input status, calibration command and trim parameter bank
`timescale 1ns/100ps
module diag_io_calib_params #(
  parameter logic [15:0] TRIM_DEFAULT   = 16'h0000,
  parameter logic [15:0] THERM_DEFAULT  = 16'h0001,
  parameter logic [15:0] MON1_DEFAULT   = 16'h0000
) (
  input  wire logic                  CLOCK,
  input  wire logic                  SYS_RST,
  input  wire logic                  WR_EN,
  input  wire logic                  RD_EN,
  input  wire logic [15:0]           ADDR,
  input  wire logic [15:0]           WR_DATA,
  input  wire logic [15:0]           PROT_MODE,
  input  wire logic                  PARAM_RESET,
  input  wire logic [8:0]            TERM_IN,
  input  wire logic [8:0]            SRC_SEL,
  input  wire logic [4:0]            KEY_IN,
  input  wire logic [4:0]            DO_STATE,
  input  wire logic                  SPEED_MODE,
  input  wire logic signed [15:0]    SPEED_AIN,
  output logic [15:0]                RD_DATA,
  output logic                       RD_VALID,
  output logic                       WR_ACK,
  output logic                       ACC_ERR,
  output logic [8:0]                 DI_FINAL,
  output logic                       CAL_START,
  output logic [4:0]                 CAL_SEL,
  output logic [8:0][15:0]           TRIMS,
  output logic [1:0][15:0]           MON_TRIMS,
  output logic signed [16:0]         SPEED_SUM
);

  diag_calib_pkg::state_t q;
  diag_calib_pkg::state_t d;

  // address decode shared by the read and write paths
  function automatic logic [4:0] reg_idx(input logic [15:0] a);
    case (a)
      diag_calib_pkg::ADDR_INPUT_STATE:  reg_idx = diag_calib_pkg::IDX_INPUT_STATE;
      diag_calib_pkg::ADDR_KEYPAD:       reg_idx = diag_calib_pkg::IDX_KEYPAD;
      diag_calib_pkg::ADDR_OUTPUT_STATE: reg_idx = diag_calib_pkg::IDX_OUTPUT_STATE;
      diag_calib_pkg::ADDR_CAL_CMD:      reg_idx = diag_calib_pkg::IDX_CAL_CMD;
      diag_calib_pkg::ADDR_SPD_TRIM_A:   reg_idx = 5'h04;
      diag_calib_pkg::ADDR_SPD_TRIM_B:   reg_idx = 5'h05;
      diag_calib_pkg::ADDR_TRQ_TRIM_A:   reg_idx = diag_calib_pkg::IDX_TRQ_TRIM_A;
      diag_calib_pkg::ADDR_V_TRIM_A:     reg_idx = 5'h08;
      diag_calib_pkg::ADDR_V_TRIM_B:     reg_idx = 5'h09;
      diag_calib_pkg::ADDR_W_TRIM_A:     reg_idx = 5'h0a;
      diag_calib_pkg::ADDR_W_TRIM_B:     reg_idx = 5'h0b;
      diag_calib_pkg::ADDR_THERM_CAL:    reg_idx = 5'h0c;
      diag_calib_pkg::ADDR_MON_TRIM1:    reg_idx = diag_calib_pkg::IDX_MON_TRIM1;
      diag_calib_pkg::ADDR_MON_TRIM2:    reg_idx = diag_calib_pkg::IDX_MON_TRIM2;
      diag_calib_pkg::ADDR_SPD_OFFSET:   reg_idx = diag_calib_pkg::IDX_SPD_OFFSET;
      default:                           reg_idx = diag_calib_pkg::IDX_NONE;
    endcase
  endfunction

  // range check of a trim slot value
  function automatic logic trim_ok(input logic [3:0] slot, input logic [15:0] v);
    if (slot == diag_calib_pkg::SLOT_THERM) begin
      trim_ok = (v >= diag_calib_pkg::THERM_MIN) && (v <= diag_calib_pkg::THERM_MAX);
    end else begin
      trim_ok = (v <= diag_calib_pkg::TRIM_MAX);
    end
  endfunction

  // signed window check
  function automatic logic in_window(input logic signed [15:0] v,
                                     input logic signed [15:0] lo,
                                     input logic signed [15:0] hi);
    in_window = (v >= lo) && (v <= hi);
  endfunction

  logic [4:0]  wr_idx;
  logic [4:0]  rd_idx;
  logic [3:0]  wr_slot;
  logic [3:0]  rd_slot;
  logic        trims_unlocked;

  assign wr_idx         = reg_idx(ADDR);
  assign rd_idx         = reg_idx(ADDR);
  assign wr_slot        = 4'(wr_idx - diag_calib_pkg::IDX_TRIM_BASE);
  assign rd_slot        = 4'(rd_idx - diag_calib_pkg::IDX_TRIM_BASE);
  assign trims_unlocked = (PROT_MODE == diag_calib_pkg::PROT_TRIM_UNLOCK);

  always_comb begin
    d           = q;
    d.rd_valid  = 1'b0;
    d.wr_ack    = 1'b0;
    d.acc_err   = 1'b0;
    d.cal_start = 1'b0;
    d.cal_sel   = 5'h00;

    // source select per input, then register the resolved state
    d.di_final = (SRC_SEL & q.sw_in) | (~SRC_SEL & TERM_IN);

    if (SPEED_MODE) begin
      d.speed_sum = 17'({SPEED_AIN[15], SPEED_AIN} + {q.spd_off[15], q.spd_off});
    end else begin
      d.speed_sum = {SPEED_AIN[15], SPEED_AIN};
    end

    // parameter reset restores defaults; mode 10 protects the trims
    if (PARAM_RESET) begin
      d.cal_cmd = diag_calib_pkg::CAL_CMD_RST;
      d.spd_off = diag_calib_pkg::SPD_OFFSET_RST;
      if (PROT_MODE != diag_calib_pkg::PROT_KEEP_TRIMS) begin
        for (int i = 0; i < diag_calib_pkg::NUM_TRIMS; i++) begin
          d.trim[i] = TRIM_DEFAULT;
        end
        d.trim[diag_calib_pkg::SLOT_THERM] = THERM_DEFAULT;
        d.mon[0] = MON1_DEFAULT;
        d.mon[1] = diag_calib_pkg::MON_TRIM2_RST;
      end
    end

    // one access port serves both keypad and communication
    if (WR_EN) begin
      d.wr_ack = 1'b1;
      case (wr_idx)
        diag_calib_pkg::IDX_INPUT_STATE: begin
          if (WR_DATA <= diag_calib_pkg::INPUT_STATE_MAX) begin
            d.sw_in = WR_DATA[8:0];
          end else begin
            d.acc_err = 1'b1;
          end
        end
        diag_calib_pkg::IDX_CAL_CMD: begin
          if (WR_DATA <= diag_calib_pkg::CAL_CMD_MAX) begin
            d.cal_cmd = WR_DATA;
            if (PROT_MODE == diag_calib_pkg::PROT_CAL_ENABLE && WR_DATA != 16'h0000) begin
              d.cal_start = 1'b1;
              if (WR_DATA == diag_calib_pkg::CAL_CMD_ALL_DRIFT) begin
                d.cal_sel = 5'h0f;
              end else if (WR_DATA == diag_calib_pkg::CAL_CMD_THERM) begin
                d.cal_sel = 5'h10;
              end else begin
                d.cal_sel = 5'(5'h01 << (WR_DATA[2:0] - 3'h1));
              end
            end
          end else begin
            d.acc_err = 1'b1;
          end
        end
        diag_calib_pkg::IDX_MON_TRIM1,
        diag_calib_pkg::IDX_MON_TRIM2: begin
          if (in_window(WR_DATA, diag_calib_pkg::MON_MIN, diag_calib_pkg::MON_MAX)) begin
            d.mon[wr_idx == diag_calib_pkg::IDX_MON_TRIM2] = WR_DATA;
          end else begin
            d.acc_err = 1'b1;
          end
        end
        diag_calib_pkg::IDX_SPD_OFFSET: begin
          if (in_window(WR_DATA, diag_calib_pkg::OFFSET_MIN, diag_calib_pkg::OFFSET_MAX)) begin
            d.spd_off = WR_DATA;
          end else begin
            d.acc_err = 1'b1;
          end
        end
        5'h04, 5'h05, 5'h06, 5'h08, 5'h09, 5'h0a, 5'h0b, 5'h0c: begin
          // the thermistor word sits at index 12, slot 8 after the skipped alias
          if (trims_unlocked && trim_ok((wr_idx == 5'h0c) ? diag_calib_pkg::SLOT_THERM
                                         : wr_slot, WR_DATA)) begin
            if (wr_idx == 5'h0c) begin
              d.trim[diag_calib_pkg::SLOT_THERM] = WR_DATA;
            end else if (wr_idx >= 5'h08) begin
              d.trim[4'(wr_slot)] = WR_DATA;
            end else begin
              d.trim[wr_slot] = WR_DATA;
            end
            // the two torque words share one address, so both are loaded
            if (wr_idx == diag_calib_pkg::IDX_TRQ_TRIM_A) begin
              d.trim[diag_calib_pkg::SLOT_TRQ_B] = WR_DATA;
            end
          end else begin
            d.acc_err = 1'b1;
          end
        end
        default: begin
          // read-only words and unmapped addresses refuse writes
          d.acc_err = 1'b1;
        end
      endcase
    end

    if (RD_EN) begin
      d.rd_valid = 1'b1;
      case (rd_idx)
        diag_calib_pkg::IDX_INPUT_STATE:  d.rd_data = {7'h00, q.di_final};
        diag_calib_pkg::IDX_KEYPAD:       d.rd_data = {11'h000, KEY_IN};
        diag_calib_pkg::IDX_OUTPUT_STATE: d.rd_data = {11'h000, DO_STATE};
        diag_calib_pkg::IDX_CAL_CMD:      d.rd_data = q.cal_cmd;
        5'h04, 5'h05, 5'h06:              d.rd_data = q.trim[rd_slot];
        5'h08, 5'h09, 5'h0a, 5'h0b:       d.rd_data = q.trim[rd_slot];
        5'h0c:                            d.rd_data = q.trim[diag_calib_pkg::SLOT_THERM];
        diag_calib_pkg::IDX_MON_TRIM1:    d.rd_data = q.mon[0];
        diag_calib_pkg::IDX_MON_TRIM2:    d.rd_data = q.mon[1];
        diag_calib_pkg::IDX_SPD_OFFSET:   d.rd_data = q.spd_off;
        default: begin
          d.rd_data = 16'h0000;
          d.acc_err = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      q.sw_in     <= 9'h000;
      q.cal_cmd   <= diag_calib_pkg::CAL_CMD_RST;
      for (int i = 0; i < diag_calib_pkg::NUM_TRIMS; i++) begin
        q.trim[i] <= TRIM_DEFAULT;
      end
      q.trim[diag_calib_pkg::SLOT_THERM] <= THERM_DEFAULT;
      q.mon[0]    <= MON1_DEFAULT;
      q.mon[1]    <= diag_calib_pkg::MON_TRIM2_RST;
      q.spd_off   <= diag_calib_pkg::SPD_OFFSET_RST;
      q.di_final  <= 9'h000;
      q.rd_data   <= 16'h0000;
      q.rd_valid  <= 1'b0;
      q.wr_ack    <= 1'b0;
      q.acc_err   <= 1'b0;
      q.cal_start <= 1'b0;
      q.cal_sel   <= 5'h00;
      q.speed_sum <= 17'h00000;
    end else begin
      q <= d;
    end
  end

  assign RD_DATA   = q.rd_data;
  assign RD_VALID  = q.rd_valid;
  assign WR_ACK    = q.wr_ack;
  assign ACC_ERR   = q.acc_err;
  assign DI_FINAL  = q.di_final;
  assign CAL_START = q.cal_start;
  assign CAL_SEL   = q.cal_sel;
  assign TRIMS     = q.trim;
  assign MON_TRIMS = q.mon;
  assign SPEED_SUM = q.speed_sum;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  sequence input_state_word_write_s;
    WR_EN && !RD_EN && ADDR == diag_calib_pkg::ADDR_INPUT_STATE
      && WR_DATA <= diag_calib_pkg::INPUT_STATE_MAX;
  endsequence

  sequence cal_write_s;
    WR_EN && ADDR == diag_calib_pkg::ADDR_CAL_CMD && !PARAM_RESET;
  endsequence

  di_resolve_a: assert property (
    ##1 DI_FINAL == (($past(SRC_SEL) & $past(q.sw_in)) | (~$past(SRC_SEL) & $past(TERM_IN))))
    else $error("resolved inputs do not follow source select");

  di_readback_a: assert property (
    RD_EN && ADDR == diag_calib_pkg::ADDR_INPUT_STATE
      |=> RD_VALID && RD_DATA == {7'h00, $past(DI_FINAL)})
    else $error("input status read does not return resolved inputs");

  sw_load_a: assert property (
    input_state_word_write_s ##1 (SRC_SEL == 9'h1ff)[*2] |-> DI_FINAL == $past(WR_DATA[8:0], 2))
    else $error("software input bits not loaded from write");

  input_state_word_range_a: assert property (
    WR_EN && ADDR == diag_calib_pkg::ADDR_INPUT_STATE
      && WR_DATA > diag_calib_pkg::INPUT_STATE_MAX |=> ACC_ERR && $stable(q.sw_in))
    else $error("out of range input status write not refused");

  key_read_a: assert property (
    RD_EN && ADDR == diag_calib_pkg::ADDR_KEYPAD |=> RD_DATA == {11'h000, $past(KEY_IN)})
    else $error("keypad word does not show key state");

  out_read_a: assert property (
    RD_EN && ADDR == diag_calib_pkg::ADDR_OUTPUT_STATE |=> RD_DATA == {11'h000, $past(DO_STATE)})
    else $error("output status word does not show outputs");

  cal_all_a: assert property (
    cal_write_s and WR_DATA == diag_calib_pkg::CAL_CMD_ALL_DRIFT
      && PROT_MODE == diag_calib_pkg::PROT_CAL_ENABLE |=> CAL_START && CAL_SEL == 5'h0f ##1 !CAL_START)
    else $error("command 5 does not start all drift calibrations");

  cal_single_a: assert property (
    cal_write_s and WR_DATA == 16'h0003 && PROT_MODE == diag_calib_pkg::PROT_CAL_ENABLE
      |=> CAL_START && CAL_SEL == 5'h04)
    else $error("command 3 does not select the v phase calibration");

  cal_lock_a: assert property (
    WR_EN && ADDR == diag_calib_pkg::ADDR_CAL_CMD
      && PROT_MODE != diag_calib_pkg::PROT_CAL_ENABLE |=> !CAL_START)
    else $error("calibration started outside protection mode 20");

  trim_lock_a: assert property (
    WR_EN && ADDR == diag_calib_pkg::ADDR_SPD_TRIM_A && !PARAM_RESET
      && PROT_MODE != diag_calib_pkg::PROT_TRIM_UNLOCK |=> ACC_ERR && $stable(TRIMS[0]))
    else $error("locked trim word was written");

  trim_keep_a: assert property (
    PARAM_RESET && !WR_EN && PROT_MODE == diag_calib_pkg::PROT_KEEP_TRIMS
      |=> $stable(TRIMS) && $stable(MON_TRIMS))
    else $error("trims lost on parameter reset in mode 10");

  therm_range_a: assert property (
    ##1 (TRIMS[diag_calib_pkg::SLOT_THERM] >= diag_calib_pkg::THERM_MIN
      && TRIMS[diag_calib_pkg::SLOT_THERM] <= diag_calib_pkg::THERM_MAX))
    else $error("thermistor word left its range");

  mon_range_a: assert property (
    ##1 in_window(MON_TRIMS[0], diag_calib_pkg::MON_MIN, diag_calib_pkg::MON_MAX))
    else $error("monitor trim left its range");

  speed_sum_a: assert property (
    SPEED_MODE |=> SPEED_SUM == 17'($past(SPEED_AIN) + $signed($past(q.spd_off))))
    else $error("speed offset not added in speed mode");

endmodule // diag_io_calib_params

//--- host_model.sv
// host controller model that issues single word reads and writes to the parameter bank
`timescale 1ns/100ps
module host_model (
  input  wire logic        clk,
  output logic             wr_en,
  output logic             rd_en,
  output logic [15:0]      addr,
  output logic [15:0]      wr_data,
  input  wire logic [15:0] rd_data,
  input  wire logic        rd_valid,
  input  wire logic        wr_ack,
  input  wire logic        acc_err,
  input  wire logic        cal_start,
  input  wire logic [4:0]  cal_sel
);
  logic [15:0] got_data;
  logic        got_done;
  logic        got_err;
  logic        got_start;
  logic [4:0]  got_sel;

  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 16'h0000;
    wr_data = 16'h0000;
  end

  // released at the taking edge since a held level would be taken again;
  // idle lines show the inverse so a stale value never passes for a fresh one
  task automatic access(input logic wr, input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    wr_en   <= wr;
    rd_en   <= ~wr;
    addr    <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en   <= 1'b0;
    rd_en   <= 1'b0;
    addr    <= ~a;
    wr_data <= ~d;
    @(posedge clk);
    got_done  = wr ? wr_ack : rd_valid;
    got_err   = acc_err;
    got_data  = rd_data;
    got_start = cal_start;
    got_sel   = cal_sel;
  endtask
endmodule // host_model

//--- test_diag_io_calib_params.sv
// self-checking bench for the diagnostic and calibration parameter bank
`timescale 1ns/100ps
module test_diag_io_calib_params;
  localparam logic [15:0] TDEF = 16'h0123;
  localparam logic [15:0] HDEF = 16'h0002;
  localparam logic [15:0] MDEF = 16'h0010;
  logic               clock       = 1'b0;
  logic               sys_rst     = 1'b1;
  logic [15:0]        prot_mode   = 16'h0000;
  logic               param_reset = 1'b0;
  logic [8:0]         term_in     = 9'h000;
  logic [8:0]         src_sel     = 9'h000;
  logic [4:0]         key_in      = 5'h00;
  logic [4:0]         do_state    = 5'h00;
  logic               speed_mode  = 1'b0;
  logic signed [15:0] speed_ain   = 16'sh0000;
  logic               wr_en, rd_en, rd_valid, wr_ack, acc_err, cal_start;
  logic [15:0]        addr, wr_data, rd_data;
  logic [8:0]         di_final;
  logic [4:0]         cal_sel;
  logic [8:0][15:0]   trims;
  logic [1:0][15:0]   mon_trims;
  logic signed [16:0] speed_sum;
  int                 err_count   = 0;
  int                 tests_run   = 0;
  int                 cycles      = 0;
  logic [31:0]        seed        = 32'd97087;
  int                 sw_m, cmd_m, off_m, st_m, sel_m;
  int                 trim_m[9];
  int                 mon_m[2];
  int                 mv[4]       = '{801, 800, -801, -800};
  int                 sv[4]       = '{5001, 5000, -5001, -5000};
  int                 taddr[$]    = '{16'h416, 16'h418, 16'h41a, 16'h41a, 16'h41e, 16'h420,
                                      16'h422, 16'h424, 16'h426};

  always #2.5 clock = ~clock;

  host_model host (.clk(clock), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data),
    .rd_data(rd_data), .rd_valid(rd_valid), .wr_ack(wr_ack), .acc_err(acc_err),
    .cal_start(cal_start), .cal_sel(cal_sel));

  diag_io_calib_params #(.TRIM_DEFAULT(TDEF), .THERM_DEFAULT(HDEF), .MON1_DEFAULT(MDEF)) uut (
    .CLOCK(clock), .SYS_RST(sys_rst), .WR_EN(wr_en), .RD_EN(rd_en), .ADDR(addr),
    .WR_DATA(wr_data), .PROT_MODE(prot_mode), .PARAM_RESET(param_reset), .TERM_IN(term_in),
    .SRC_SEL(src_sel), .KEY_IN(key_in), .DO_STATE(do_state), .SPEED_MODE(speed_mode),
    .SPEED_AIN(speed_ain), .RD_DATA(rd_data), .RD_VALID(rd_valid), .WR_ACK(wr_ack),
    .ACC_ERR(acc_err), .DI_FINAL(di_final), .CAL_START(cal_start), .CAL_SEL(cal_sel),
    .TRIMS(trims), .MON_TRIMS(mon_trims), .SPEED_SUM(speed_sum));

  function automatic int rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return int'(seed);
  endfunction

  function automatic int tslot(input int a);
    foreach (taddr[i]) if (taddr[i] == a) return i;
    return -1;
  endfunction

  function automatic bit mapped(input int a);
    return tslot(a) >= 0 ||
           a inside {16'h40e, 16'h410, 16'h412, 16'h414, 16'h428, 16'h42a, 16'h42c};
  endfunction

  function automatic int di_exp();
    return int'((term_in & ~src_sel) | (sw_m[8:0] & src_sel));
  endfunction

  function automatic int model_rd(input int a);
    case (a)
      16'h040e: return di_exp();
      16'h0410: return key_in;
      16'h0412: return do_state;
      16'h0414: return cmd_m;
      16'h0428: return mon_m[0];
      16'h042a: return mon_m[1];
      16'h042c: return off_m;
      default: return (tslot(a) >= 0) ? trim_m[tslot(a)] : 0;
    endcase
  endfunction

  task automatic model_reset(input bit keep);
    cmd_m = 0;
    off_m = 0;
    if (!keep) begin
      foreach (trim_m[i]) trim_m[i] = (i == 8) ? HDEF : TDEF;
      mon_m[0] = MDEF;
      mon_m[1] = 0;
    end
  endtask

  task automatic model_wr(input int a, input int d, output bit err);
    int s;
    int p;
    s = int'($signed(d[15:0]));
    p = int'(prot_mode);
    err = 1'b1;
    case (a)
      16'h040e: err = d > 16'h01ff;
      16'h0414: err = d > 6;
      16'h0428, 16'h042a: err = s < -800 || s > 800;
      16'h042c: err = s < -5000 || s > 5000;
      16'h0426: err = p != 22 || d < 1 || d > 3;
      default: if (tslot(a) >= 0) err = p != 22 || d > 32767;
    endcase
    st_m = !err && a == 16'h0414 && p == 20 && d > 0;
    sel_m = (d == 5) ? 5'h0f : (d == 6) ? 5'h10 : 1 << (d - 1);
    if (!err) begin
      if (a == 16'h040e) sw_m = d;
      if (a == 16'h0414) cmd_m = d;
      if (a == 16'h0428) mon_m[0] = d & 16'hffff;
      if (a == 16'h042a) mon_m[1] = d & 16'hffff;
      if (a == 16'h042c) off_m = d & 16'hffff;
      if (tslot(a) >= 0) trim_m[tslot(a)] = d;
      if (a == 16'h041a) trim_m[3] = d;
    end
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input int a, input int d);
    bit e;
    host.access(1'b1, a[15:0], d[15:0]);
    model_wr(a, d, e);
    check(host.got_err, e);
    check(host.got_done, 1'b1);
    check(host.got_start, st_m);
    if (st_m) check(host.got_sel, sel_m);
  endtask

  task automatic rd(input int a);
    host.access(1'b0, a[15:0], 16'h0000);
    check(host.got_err, !mapped(a));
    if (mapped(a)) check(host.got_done, 1'b1);
    check(host.got_data, model_rd(a));
  endtask

  task automatic check_ports();
    repeat (2) @(posedge clock);
    foreach (trim_m[i]) check(trims[i], trim_m[i]);
    foreach (mon_m[i]) check(mon_trims[i], mon_m[i]);
  endtask

  task automatic pr(input logic [15:0] p);
    @(posedge clock);
    prot_mode   <= p;
    param_reset <= 1'b1;
    @(posedge clock);
    param_reset <= 1'b0;
    model_reset(p == 16'd10);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      err_count++;
      tally_and_finish();
    end
  end

  initial begin
    sw_m = 0;
    model_reset(1'b0);
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    for (int a = 16'h40e; a <= 16'h42c; a += 2) rd(a);
    check_ports();
    $display("test reset values done");
    wr(16'h040e, 16'h0200);
    wr(16'h0410, 16'h0001);
    wr(16'h041c, 16'h0001);
    repeat (4) begin
      term_in  <= 9'(rnd());
      src_sel  <= 9'(rnd());
      key_in   <= 5'(rnd());
      do_state <= 5'(rnd());
      wr(16'h040e, rnd() & 16'h01ff);
      check_ports();
      check(di_final, di_exp());
      rd(16'h040e);
      rd(16'h0410);
      rd(16'h0412);
    end
    src_sel <= 9'h1ff;
    wr(16'h040e, 16'h01ff);
    check_ports();
    check(di_final, di_exp());
    $display("test input status done");
    prot_mode <= 16'd20;
    for (int d = 0; d < 8; d++) wr(16'h0414, d);
    prot_mode <= 16'd0;
    wr(16'h0414, 5);
    rd(16'h0414);
    $display("test calibration done");
    wr(16'h0416, 16'h0064);
    prot_mode <= 16'd22;
    foreach (taddr[i]) wr(taddr[i], (i == 8) ? 3 : rnd() & 16'h7fff);
    wr(16'h0418, 16'h8000);
    wr(16'h0418, 16'h7fff);
    foreach (taddr[i]) rd(taddr[i]);
    for (int d = 0; d < 5; d++) wr(16'h0426, d);
    check_ports();
    $display("test trims done");
    foreach (mv[i]) begin
      wr(16'h0428, mv[i]);
      wr(16'h042a, -mv[i]);
      wr(16'h042c, sv[i]);
    end
    for (int m = 0; m < 2; m++) begin
      speed_mode <= m[0];
      speed_ain  <= 16'(rnd());
      repeat (2) @(posedge clock);
      check(speed_sum, 32'(int'(speed_ain) + (m ? int'($signed(16'(off_m))) : 0)));
    end
    $display("test monitor and offset done");
    pr(16'd10);
    check_ports();
    pr(16'd0);
    check_ports();
    rd(16'h0414);
    rd(16'h042c);
    $display("test parameter reset done");
    tally_and_finish();
  end
endmodule // test_diag_io_calib_params
